/* core/utfr_core.sv */
// usb token and frame register slice with axi4-lite access
// assumes the packet engine consumes the token request and reports done;
// received frame-start tokens arrive as a pulse with their 11-bit number
//
// Overview of operation
// - the slow select bit in the address register picks low speed for the next token.
// - a seven-bit function address sits in bits 6..0 of the address register, read/write.
// - the low eight bits of the frame number are reloaded on each received frame start.
// - the top three frame number bits sit in bits 2..0 of the high register, same update.
// - token type codes 1101, 1001 and 0001 issue setup, in and out tokens.
// - the threshold register holds an eight-bit read/write count that resets to zero.
// - bits 31..8 of address, frame-low, token and threshold read zero, writes ignored.
// - bits 31..3 of the frame-high register read zero.
// - in host mode with frame starts enabled a frame start is sent every millisecond.
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module utfr_core
  import utfr_pkg::*;
#(
  parameter int FRAME_CYCLES = UTFR_FRAME_CYCLES  // frame-start period in cycles
) (
  input  wire logic        aclk,             // system clock
  input  wire logic        aresetn,          // sync reset, active low
  input  wire logic        ce,               // clock enable, freezes all state
  input  wire logic [7:0]  s_axi_awaddr,     // write address
  input  wire logic        s_axi_awvalid,    // write address valid
  output logic             s_axi_awready,    // write address ready
  input  wire logic [31:0] s_axi_wdata,      // write data
  input  wire logic [3:0]  s_axi_wstrb,      // byte strobes
  input  wire logic        s_axi_wvalid,     // write data valid
  output logic             s_axi_wready,     // write data ready
  output logic [1:0]       s_axi_bresp,      // write response
  output logic             s_axi_bvalid,     // write response valid
  input  wire logic        s_axi_bready,     // write response ready
  input  wire logic [7:0]  s_axi_araddr,     // read address
  input  wire logic        s_axi_arvalid,    // read address valid
  output logic             s_axi_arready,    // read address ready
  output logic [31:0]      s_axi_rdata,      // read data
  output logic [1:0]       s_axi_rresp,      // read response
  output logic             s_axi_rvalid,     // read valid
  input  wire logic        s_axi_rready,     // read ready
  input  wire logic        sof_rx,           // pulse: frame start token received
  input  wire logic [10:0] sof_rx_frame,     // frame number carried by that token
  input  wire logic        token_done,       // pulse: engine finished the token
  output logic             token_start,      // pulse: start one transaction
  output logic [3:0]       token_pid,        // token type to send
  output logic [3:0]       token_endpoint,   // endpoint to address
  output logic [6:0]       token_address,    // function address to use
  output logic             token_slow,       // run at low speed
  output logic             token_in_progress,// token busy
  output logic             sof_send,         // pulse: send a frame start now
  output logic [7:0]       sof_threshold     // threshold count to engine
);
  logic                 wr_en;
  logic [7:0]           wr_addr;
  logic [31:0]          wr_data;
  logic [3:0]           wr_strb;
  logic                 wr_ok;
  logic [7:0]           rd_addr;
  logic [31:0]          rd_data;
  logic                 rd_ok;
  logic                 slow_token_select;
  logic [6:0]           function_address_field;
  logic [7:0]           frame_number_low_bits;
  logic [2:0]           frame_number_high_bits;
  logic [3:0]           token_type_field;
  logic [3:0]           token_endpoint_field;
  logic [7:0]           threshold_count;
  logic                 host_enable;
  logic                 frame_start_generate_enable;
  logic                 tick;
  logic                 tok_write;
  utfr_tok_state_t      tok_state;

  // true when a low-lane write to the given register is happening
  function automatic logic lane0_write(input logic [7:0] a, input logic [7:0] target,
                                       input logic en, input logic [3:0] strb);
    return en && (a == target) && strb[0];
  endfunction

  // pad an 8-bit field to a bus word; upper bits read zero
  function automatic logic [31:0] word8(input logic [7:0] v);
    return {24'h00_0000, v};
  endfunction

  utfr_axil_slave u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_ok),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  // read-only registers accept the write handshake but return an error
  always_comb begin
    wr_ok = (wr_addr == UTFR_ADDR_FUNCTION_ADDRESS) || (wr_addr == UTFR_ADDR_TOKEN_COMMAND)
         || (wr_addr == UTFR_ADDR_THRESHOLD) || (wr_addr == UTFR_ADDR_CONTROL);
  end

  // address register: slow select and function address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slow_token_select      <= 1'b0;
      function_address_field <= 7'h00;
    end else if (ce && lane0_write(wr_addr, UTFR_ADDR_FUNCTION_ADDRESS, wr_en, wr_strb)) begin
      slow_token_select      <= wr_data[UTFR_SLOW_BIT];
      function_address_field <= wr_data[UTFR_SLOW_BIT-1:0];
    end
  end

  // threshold count; upper write bits dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      threshold_count <= UTFR_BYTE_RESET;
    end else if (ce && lane0_write(wr_addr, UTFR_ADDR_THRESHOLD, wr_en, wr_strb)) begin
      threshold_count <= wr_data[7:0];
    end
  end

  // control: host mode and frame-start generation enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_enable                 <= 1'b0;
      frame_start_generate_enable <= 1'b0;
    end else if (ce && lane0_write(wr_addr, UTFR_ADDR_CONTROL, wr_en, wr_strb)) begin
      host_enable                 <= wr_data[UTFR_CTL_HOST_BIT];
      frame_start_generate_enable <= wr_data[UTFR_CTL_SOF_BIT];
    end
  end

  // frame number reloads only on a received frame start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_number_low_bits  <= UTFR_BYTE_RESET;
      frame_number_high_bits <= 3'h0;
    end else if (ce && sof_rx) begin
      frame_number_low_bits  <= sof_rx_frame[UTFR_FRAME_LOW_W-1:0];
      frame_number_high_bits <= sof_rx_frame[UTFR_FRAME_W-1:UTFR_FRAME_LOW_W];
    end
  end

  assign tok_write = lane0_write(wr_addr, UTFR_ADDR_TOKEN_COMMAND, wr_en, wr_strb);

  // token register always stores, so software can read back what it wrote
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      token_type_field     <= 4'h0;
      token_endpoint_field <= 4'h0;
    end else if (ce && tok_write) begin
      token_type_field     <= wr_data[7:4];
      token_endpoint_field <= wr_data[3:0];
    end
  end

  // token sequencer; reserved codes and device-mode writes start nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tok_state         <= UTFR_TK_IDLE;
      token_start       <= 1'b0;
      token_in_progress <= 1'b0;
      token_pid         <= 4'h0;
      token_endpoint    <= 4'h0;
      token_address     <= 7'h00;
      token_slow        <= 1'b0;
    end else if (ce) begin
      token_start <= 1'b0;
      unique case (tok_state)
        UTFR_TK_IDLE: begin
          if (tok_write && host_enable &&
              (wr_data[7:4] == UTFR_PID_SETUP || wr_data[7:4] == UTFR_PID_IN ||
               wr_data[7:4] == UTFR_PID_OUT)) begin
            tok_state         <= UTFR_TK_ISSUE;
            token_in_progress <= 1'b1;
          end
        end
        UTFR_TK_ISSUE: begin
          // snapshot settings so later register writes cannot disturb the transaction
          token_pid      <= token_type_field;
          token_endpoint <= token_endpoint_field;
          token_address  <= function_address_field;
          token_slow     <= slow_token_select;
          token_start    <= 1'b1;
          tok_state      <= UTFR_TK_WAIT;
        end
        UTFR_TK_WAIT: begin
          // a new token write here is ignored; software must poll busy first
          if (token_done || !host_enable) begin
            tok_state         <= UTFR_TK_IDLE;
            token_in_progress <= 1'b0;
          end
        end
      endcase
    end
  end

  utfr_frame_timer #(
    .PERIOD_CYCLES (FRAME_CYCLES)
  ) u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .run     (host_enable && frame_start_generate_enable),
    .tick    (tick)
  );

  // registered copies to the engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sof_send      <= 1'b0;
      sof_threshold <= UTFR_BYTE_RESET;
    end else if (ce) begin
      sof_send      <= tick;
      sof_threshold <= threshold_count;
    end
  end

  // read mux; unimplemented bits read zero
  always_comb begin
    rd_ok   = 1'b1;
    rd_data = 32'h0000_0000;
    unique case (rd_addr)
      UTFR_ADDR_FUNCTION_ADDRESS: rd_data = word8({slow_token_select, function_address_field});
      UTFR_ADDR_FRAME_LOW:        rd_data = word8(frame_number_low_bits);
      UTFR_ADDR_FRAME_HIGH:       rd_data = {29'h0, frame_number_high_bits};
      UTFR_ADDR_TOKEN_COMMAND:    rd_data = word8({token_type_field, token_endpoint_field});
      UTFR_ADDR_THRESHOLD:        rd_data = word8(threshold_count);
      UTFR_ADDR_CONTROL:          rd_data = {30'h0, frame_start_generate_enable, host_enable};
      UTFR_ADDR_STATUS:           rd_data = {31'h0, token_in_progress};
      default:                    rd_ok   = 1'b0;
    endcase
  end

  sequence s_tok_go;
    ce && tok_write && host_enable && !token_in_progress &&
    (wr_data[7:4] == UTFR_PID_IN);
  endsequence

  a_token_start_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    s_tok_go |-> ##1 token_in_progress ##1 (ce ? token_start : 1'b1))
    else $error("token write did not start a transaction");

  a_token_pid_match: assert property (@(posedge aclk) disable iff (!aresetn)
    token_start |-> (token_pid == UTFR_PID_SETUP || token_pid == UTFR_PID_IN ||
                     token_pid == UTFR_PID_OUT))
    else $error("transaction started with a reserved token type");

  a_token_slow_copy: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && tok_state == UTFR_TK_ISSUE) |=> (token_slow == $past(slow_token_select)))
    else $error("token speed differs from slow select");

  a_addr_readback: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && lane0_write(wr_addr, UTFR_ADDR_FUNCTION_ADDRESS, wr_en, wr_strb))
      |=> (function_address_field == $past(wr_data[6:0])))
    else $error("function address not stored");

  a_frame_reload: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && sof_rx) |=> ({frame_number_high_bits, frame_number_low_bits}
                        == $past(sof_rx_frame)))
    else $error("frame number not reloaded");

  a_frame_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !sof_rx |=> $stable(frame_number_low_bits) && $stable(frame_number_high_bits))
    else $error("frame number changed without a frame start");

  a_threshold_reset: assert property (@(posedge aclk)
    !aresetn |=> threshold_count == 8'h00)
    else $error("threshold count not cleared by reset");

  a_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("unimplemented upper bits read nonzero");

  a_high_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && s_axi_arvalid && s_axi_arready && s_axi_araddr == UTFR_ADDR_FRAME_HIGH)
      |=> s_axi_rdata[31:3] == 29'h0)
    else $error("frame high upper bits read nonzero");

  a_sof_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    sof_send |-> $past(host_enable, 2) && $past(frame_start_generate_enable, 2))
    else $error("frame start sent while generation disabled");
endmodule

/* core/utfr_pkg.sv */
// package for the usb token / frame register slice
// assumes a 200 MHz system clock and a 32-bit axi4-lite register bus
package utfr_pkg;
  // register byte addresses
  localparam logic [7:0] UTFR_ADDR_FUNCTION_ADDRESS = 8'h00;
  localparam logic [7:0] UTFR_ADDR_FRAME_LOW        = 8'h04;
  localparam logic [7:0] UTFR_ADDR_FRAME_HIGH       = 8'h08;
  localparam logic [7:0] UTFR_ADDR_TOKEN_COMMAND    = 8'h0C;
  localparam logic [7:0] UTFR_ADDR_THRESHOLD        = 8'h10;
  localparam logic [7:0] UTFR_ADDR_CONTROL          = 8'h14;
  localparam logic [7:0] UTFR_ADDR_STATUS           = 8'h18;
  // field positions
  localparam int UTFR_SLOW_BIT      = 7;
  localparam int UTFR_FRAME_W       = 11;
  localparam int UTFR_FRAME_LOW_W   = 8;
  localparam int UTFR_FRAME_HIGH_W  = 3;
  localparam int UTFR_CTL_HOST_BIT  = 0;
  localparam int UTFR_CTL_SOF_BIT   = 1;
  // reset values
  localparam logic [7:0] UTFR_BYTE_RESET = 8'h00;
  // token type codes
  localparam logic [3:0] UTFR_PID_SETUP = 4'hD;
  localparam logic [3:0] UTFR_PID_IN    = 4'h9;
  localparam logic [3:0] UTFR_PID_OUT   = 4'h1;
  // axi responses
  localparam logic [1:0] UTFR_RESP_OKAY   = 2'h0;
  localparam logic [1:0] UTFR_RESP_SLVERR = 2'h2;
  // frame period
  localparam int UTFR_CLK_MHZ        = 200;
  localparam int UTFR_FRAME_PERIOD_US = 1000;
  localparam int UTFR_FRAME_CYCLES   = UTFR_FRAME_PERIOD_US * UTFR_CLK_MHZ;
  typedef enum logic [1:0] {UTFR_TK_IDLE, UTFR_TK_ISSUE, UTFR_TK_WAIT} utfr_tok_state_t;
endpackage

/* core/utfr_axil_slave.sv */
// axi4-lite slave front end: one write and one read at a time
// assumes the core register file answers reads combinationally from rd_addr
`timescale 1ns/1ps
module utfr_axil_slave
  import utfr_pkg::*;
(
  input  wire logic        aclk,      // system clock
  input  wire logic        aresetn,   // sync reset, active low
  input  wire logic        ce,        // clock enable
  input  wire logic [7:0]  awaddr,    // write address
  input  wire logic        awvalid,   // write address valid
  output logic             awready,   // write address ready
  input  wire logic [31:0] wdata,     // write data
  input  wire logic [3:0]  wstrb,     // byte strobes
  input  wire logic        wvalid,    // write data valid
  output logic             wready,    // write data ready
  output logic [1:0]       bresp,     // write response
  output logic             bvalid,    // write response valid
  input  wire logic        bready,    // write response ready
  input  wire logic [7:0]  araddr,    // read address
  input  wire logic        arvalid,   // read address valid
  output logic             arready,   // read address ready
  output logic [31:0]      rdata,     // read data
  output logic [1:0]       rresp,     // read response
  output logic             rvalid,    // read valid
  input  wire logic        rready,    // read ready
  output logic             wr_en,     // one-cycle register write pulse
  output logic [7:0]       wr_addr,   // write address to core
  output logic [31:0]      wr_data,   // write data to core
  output logic [3:0]       wr_strb,   // write strobes to core
  input  wire logic        wr_ok,     // address maps to a writable register
  output logic [7:0]       rd_addr,   // read address to core
  input  wire logic [31:0] rd_data,   // read data from core
  input  wire logic        rd_ok      // address maps to a register
);
  logic aw_held;
  logic w_held;

  // address and data captured in either order; write fires once both held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      wr_en   <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= UTFR_RESP_OKAY;
    end else if (ce) begin
      wr_en <= 1'b0;
      if (awvalid && awready) begin
        wr_addr <= awaddr;
        aw_held <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wr_data <= wdata;
        wr_strb <= wstrb;
        w_held  <= 1'b1;
        wready  <= 1'b0;
      end
      if (aw_held && w_held && !bvalid) begin
        wr_en   <= wr_ok;
        bresp   <= wr_ok ? UTFR_RESP_OKAY : UTFR_RESP_SLVERR;
        bvalid  <= 1'b1;
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  assign rd_addr = araddr;

  // read data is latched the edge the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= UTFR_RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        rdata   <= rd_ok ? rd_data : 32'h0000_0000;
        rresp   <= rd_ok ? UTFR_RESP_OKAY : UTFR_RESP_SLVERR;
        rvalid  <= 1'b1;
        arready <= 1'b0;
      end else if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule

/* core/utfr_frame_timer.sv */
// host frame-start timer: pulses once per frame period while enabled
// assumes a free-running system clock; period given in cycles
`timescale 1ns/1ps
module utfr_frame_timer #(
  parameter int PERIOD_CYCLES = 200000  // one millisecond at 200 MHz
) (
  input  wire logic aclk,     // system clock
  input  wire logic aresetn,  // sync reset, active low
  input  wire logic ce,       // clock enable
  input  wire logic run,      // host mode and frame starts enabled
  output logic      tick      // one-cycle pulse per frame
);
  localparam int CW = $clog2(PERIOD_CYCLES);
  localparam logic [CW-1:0] LAST = CW'(PERIOD_CYCLES - 1);
  logic [CW-1:0] count;

  // restarts from zero whenever generation is switched off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (ce) begin
      tick <= 1'b0;
      if (!run) begin
        count <= '0;
      end else if (count == LAST) begin
        count <= '0;
        tick  <= 1'b1;
      end else begin
        count <= count + CW'(1);
      end
    end
  end
endmodule

/* verification/utfr_engine_model.sv */
// packet engine and usb wire partner: finishes tokens, delivers frame starts
// assumes it shares the core clock; the bench picks the token duration
`timescale 1ns/1ps
module utfr_engine_model (
  input  wire logic        aclk,              // system clock
  input  wire logic        aresetn,           // sync reset, active low
  input  wire logic        token_start,       // start pulse from the core
  input  wire logic [7:0]  delay,             // extra cycles a token lasts
  output logic             token_done,        // finish pulse to the core
  output logic             sof_rx = 1'b0,     // frame start received
  output logic [10:0]      sof_rx_frame = '0  // frame number with that pulse
);
  logic [8:0] left;  // cycles left in the running token
  // a long delay keeps the core busy across later token writes
  always @(posedge aclk) begin
    if (!aresetn) left <= 9'h000;
    else if (token_start) left <= {1'b0, delay} + 9'h001;
    else if (left != 9'h000) left <= left - 9'h001;
    token_done <= aresetn && left == 9'h001;
  end
  // the number stands with its pulse only, then shows its inverse
  task automatic send_sof(input logic [10:0] f);
    @(posedge aclk);
    sof_rx <= 1'b1;
    sof_rx_frame <= f;
    @(posedge aclk);
    sof_rx <= 1'b0;
    sof_rx_frame <= ~f;
  endtask
endmodule

/* verification/tb.sv */
// self-checking bench for the token / frame register slice
// assumes axi4-lite master tasks here and the engine model on the far side
`timescale 1ns/1ps
module tb;
  import utfr_pkg::*;
  localparam int FC = 50;  // short frame period keeps the run brief
  logic aclk = 0, aresetn = 0, ce = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, sof_threshold, dly = 8'h02;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF, token_pid, token_endpoint;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, sof_rx, token_done;
  logic token_start, token_slow, token_in_progress, sof_send;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [6:0] token_address;
  logic [10:0] sof_rx_frame, f;
  logic [33:0] bq[$], rq[$], tq[$];
  logic [3:0] pids[3] = '{UTFR_PID_SETUP, UTFR_PID_IN, UTFR_PID_OUT};
  int n_mismatch = 0, check_count = 0, n_sof = 0, cyc = 0, last_sof = -1, k;
  always #2.5 aclk = ~aclk;
  utfr_core #(.FRAME_CYCLES(FC)) i_utfr_core (.*);
  utfr_engine_model i_utfr_engine_model (.aclk, .aresetn, .token_start, .delay(dly),
    .token_done, .sof_rx, .sof_rx_frame);
  task automatic check(input string nm, input logic [33:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task end_of_test;
    if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    bq.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    fork
      begin
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 0;
      end
      begin
        do @(posedge aclk); while (s_axi_wready !== 1'b1);
        s_axi_wvalid <= 0;
      end
    join
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] v);
    rq.push_back({r, v});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
  endtask
  // software waits for the busy flag to drop before the next token
  task automatic wait_idle;
    repeat (2) @(posedge aclk);
    while (token_in_progress !== 1'b0) @(posedge aclk);
  endtask
  // monitor: every answer takes the oldest note; a start with no note is wrong
  always @(posedge aclk) begin
    cyc++;
    if (s_axi_bvalid && s_axi_bready) check("bresp", s_axi_bresp, bq.pop_front());
    if (s_axi_rvalid && s_axi_rready) check("rdata", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (token_start) check("token", {token_pid, token_endpoint, token_address, token_slow},
      tq.size() > 0 ? tq.pop_front() : '1);
    if (sof_send) begin
      if (last_sof >= 0) check("frame gap", cyc - last_sof, FC);
      last_sof = cyc;
      n_sof++;
    end
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    end_of_test;
  end
  initial begin
    void'($urandom(32'h234f));
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    for (int i = 0; i < 5; i++) rd(8'(4 * i), UTFR_RESP_OKAY, 32'h0);
    d = $urandom;
    wr(UTFR_ADDR_FUNCTION_ADDRESS, d, UTFR_RESP_OKAY);
    rd(UTFR_ADDR_FUNCTION_ADDRESS, UTFR_RESP_OKAY, {24'h0, d[7:0]});
    wr(UTFR_ADDR_THRESHOLD, 32'hA5A5A54A, UTFR_RESP_OKAY);
    rd(UTFR_ADDR_THRESHOLD, UTFR_RESP_OKAY, 32'h4A);
    check("threshold", sof_threshold, 8'h4A);
    wr(UTFR_ADDR_FRAME_LOW, 32'hFF, UTFR_RESP_SLVERR);
    wr(UTFR_ADDR_FRAME_HIGH, 32'h7, UTFR_RESP_SLVERR);
    rd(8'h1C, UTFR_RESP_SLVERR, 32'h0);
    repeat (2) begin
      f = 11'($urandom);
      i_utfr_engine_model.send_sof(f);
      rd(UTFR_ADDR_FRAME_LOW, UTFR_RESP_OKAY, {24'h0, f[7:0]});
      rd(UTFR_ADDR_FRAME_HIGH, UTFR_RESP_OKAY, {29'h0, f[10:8]});
    end
    // clock enable low: a frame start in that cycle must leave the number alone
    ce <= 1'b0;
    i_utfr_engine_model.send_sof(~f);
    ce <= 1'b1;
    rd(UTFR_ADDR_FRAME_LOW, UTFR_RESP_OKAY, {24'h0, f[7:0]});
    rd(UTFR_ADDR_FRAME_HIGH, UTFR_RESP_OKAY, {29'h0, f[10:8]});
    // host mode: every token type, random address, speed and endpoint
    wr(UTFR_ADDR_CONTROL, 32'h1, UTFR_RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      d = $urandom;
      wr(UTFR_ADDR_FUNCTION_ADDRESS, d, UTFR_RESP_OKAY);
      tq.push_back({pids[i], d[11:8], d[6:0], d[7]});
      wr(UTFR_ADDR_TOKEN_COMMAND, {d[23:0], pids[i], d[11:8]}, UTFR_RESP_OKAY);
      wait_idle;
    end
    rd(UTFR_ADDR_TOKEN_COMMAND, UTFR_RESP_OKAY, {24'h0, UTFR_PID_OUT, d[11:8]});
    // a second token while busy is refused, as are reserved and device-mode ones
    dly <= 8'd30;
    tq.push_back({UTFR_PID_OUT, 4'h3, d[6:0], d[7]});
    wr(UTFR_ADDR_TOKEN_COMMAND, {24'h0, UTFR_PID_OUT, 4'h3}, UTFR_RESP_OKAY);
    rd(UTFR_ADDR_STATUS, UTFR_RESP_OKAY, 32'h1);
    wr(UTFR_ADDR_TOKEN_COMMAND, {24'h0, UTFR_PID_IN, 4'h5}, UTFR_RESP_OKAY);
    wait_idle;
    rd(UTFR_ADDR_STATUS, UTFR_RESP_OKAY, 32'h0);
    wr(UTFR_ADDR_TOKEN_COMMAND, 32'h25, UTFR_RESP_OKAY);
    wait_idle;
    wr(UTFR_ADDR_CONTROL, 32'h0, UTFR_RESP_OKAY);
    wr(UTFR_ADDR_TOKEN_COMMAND, 32'h91, UTFR_RESP_OKAY);
    repeat (10) @(posedge aclk);
    // frame starts run only while host mode and generation are both on
    wr(UTFR_ADDR_CONTROL, 32'h3, UTFR_RESP_OKAY);
    rd(UTFR_ADDR_CONTROL, UTFR_RESP_OKAY, 32'h3);
    repeat (4 * FC) @(posedge aclk);
    check("frame count", n_sof >= 3, 1'b1);
    wr(UTFR_ADDR_CONTROL, 32'h0, UTFR_RESP_OKAY);
    k = n_sof;
    repeat (3 * FC) @(posedge aclk);
    check("frame stop", n_sof, k);
    end_of_test;
  end
endmodule
